// ---- pkg/arr_cfg.svh ----
/*
 Constants of the angle readout block: serial offsets, word fields,
 reset values and timing counts. Assumes a 25 MHz system clock.
*/
// Function
// R1: Run a main low-latency angle path and a low-power secondary path.
// R2: New angle value ready about every microsecond, 1 MHz refresh.
// R3: Averaging off, sample to encoder outputs takes about 7 us.
// R4: Angle width returned depends only on serial address read.
// R5: Word 0x20: zero, error flag, low supply flag, parity, 12-bit angle.
// R6: Word 0x32: zero then 15-bit angle, no status bits.
// R7: Every 12-bit angle read carries error, low supply and parity bits.
// R8: Low supply flag set while supply is below operating range.
// R9: Pulse-width output always uses the 12-bit angle.
// R10: Incremental and commutation outputs use the 15-bit angle.
// R11: Stored zero-position offset is subtracted from the computed angle.
// R12: Serial access valid about 300 us after power-on.
// R13: Offset, filtering and diagnostics each enabled by stored config bits.
// R14: One full field rotation maps onto the full code range.
// R15: Parity bit makes the 12-bit word odd over all sixteen bits.
// R16: Read data latched on first serial clock edge of response frame.
// R17: Secondary path angle refreshed about every 32 us.
// R18: Field strength register refreshed about every 128 us.
// R19: Power-up reloads shadow config and resets serial registers.
`ifndef ARR_CFG_SVH
`define ARR_CFG_SVH

// Serial register offsets
`define ARR_REG_ANG12     8'h20
`define ARR_REG_FIELD     8'h2A
`define ARR_REG_ANG15     8'h32
// Fields of the 12-bit word
`define ARR_W12_ERR       14
`define ARR_W12_LOWSUP    13
`define ARR_W12_PAR       12
// Command frame address field
`define ARR_CMD_ADR_HI    13
`define ARR_CMD_ADR_LO    8
`define ARR_FRAME_BITS    16
// Reset values and diagnostic limit
`define ARR_ANGLE_RST     15'h0000
`define ARR_WORD_RST      16'h0000
`define ARR_DIAG_LIM      15'h0400
// Timing, in ns, and cycle counts
`define ARR_CLK_NS        40
`define ARR_ANG_NS        1000
`define ARR_RESP_NS       7000
`define ARR_LP_NS         32000
`define ARR_FIELD_NS      128000
`define ARR_POR_NS        300000
`define ARR_ANG_CYC       (`ARR_ANG_NS / `ARR_CLK_NS)
`define ARR_RESP_TAPS     (`ARR_RESP_NS / `ARR_ANG_NS)
`define ARR_LP_CYC        (`ARR_LP_NS / `ARR_CLK_NS)
`define ARR_FIELD_CYC     (`ARR_FIELD_NS / `ARR_CLK_NS)
`define ARR_POR_CYC       (`ARR_POR_NS / `ARR_CLK_NS)

`endif

// ---- pkg/arr_pkg.sv ----
/*
 Types shared by the angle readout modules.
 Assumes arr_cfg.svh holds the numbers.
*/
package arr_pkg;
    typedef logic [14:0] arr_angle_t;
    typedef logic [15:0] arr_word_t;
    typedef logic [7:0]  arr_addr_t;
    typedef logic [2:0]  arr_rate_t;
    // Serial frame states, one-hot
    typedef enum logic [1:0] {
        ARR_IDLE  = 2'b01,
        ARR_SHIFT = 2'b10
    } arr_spi_state_t;
endpackage : arr_pkg

// ---- pkg/arr_rd_if.sv ----
/*
 Read port between the serial slave and the register mux.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ns
interface arr_rd_if;
    arr_pkg::arr_addr_t reqAddr;
    logic               capture;
    arr_pkg::arr_word_t rdData;
    modport regs   (input reqAddr, input capture, output rdData);
    modport serial (output reqAddr, output capture, input rdData);
endinterface : arr_rd_if

// ---- rtl/arr_serial.sv ----
/*
 Serial slave: samples the serial pins on clk_sys, shifts command frames
 in and read words out. Assumes mode 0 framing and a link clock at least
 eight times slower than clk_sys.
*/
`timescale 1ns/1ns
`include "arr_cfg.svh"
module arr_serial (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  sys_rst,
    // Frames accepted only when high
    input  wire logic  enable,
    // Serial pins
    input  wire logic  sclk,
    input  wire logic  csN,
    input  wire logic  mosi,
    output logic       miso,
    output logic       misoOeN,
    // Register read port
    arr_rd_if.serial   rd
);
    import arr_pkg::*;

    logic [2:0]     sclkS_q;
    logic [1:0]     csS_q;
    logic [1:0]     mosiS_q;
    logic           sclkRise;
    logic           sclkFall;
    arr_spi_state_t state_q;
    logic [4:0]     bitCnt_q;
    arr_word_t      rxShift_q;
    arr_word_t      txShift_q;
    arr_addr_t      addr_q;

    // Two-stage synchronisers; third sclk stage only feeds the edge finder
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sclkS_q <= 3'h0;
            csS_q   <= 2'h3;
            mosiS_q <= 2'h0;
        end else begin
            sclkS_q <= {sclkS_q[1:0], sclk};
            csS_q   <= {csS_q[0], csN};
            mosiS_q <= {mosiS_q[0], mosi};
        end
    end

    assign sclkRise = sclkS_q[1] & ~sclkS_q[2];
    assign sclkFall = ~sclkS_q[1] & sclkS_q[2];

    // Read word is frozen on the first rising edge of the frame
    // A select that ends on the same edge cancels the latch
    assign rd.capture = (state_q == ARR_SHIFT) && !csS_q[1] && sclkRise
                        && (bitCnt_q == 5'h00); // R16
    assign rd.reqAddr = addr_q;

    // Frame sequencing; address of a full frame serves the next frame
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q   <= ARR_IDLE;
            bitCnt_q  <= 5'h00;
            rxShift_q <= `ARR_WORD_RST;
            txShift_q <= `ARR_WORD_RST;
            addr_q    <= 8'h00; // R19
        end else begin
            case (state_q)
                ARR_IDLE: begin
                    if (!csS_q[1] && enable) begin // R12
                        state_q   <= ARR_SHIFT;
                        bitCnt_q  <= 5'h00;
                        txShift_q <= `ARR_WORD_RST;
                    end
                end
                ARR_SHIFT: begin
                    if (csS_q[1]) begin
                        state_q <= ARR_IDLE;
                        if (bitCnt_q == 5'(`ARR_FRAME_BITS))
                            addr_q <= {2'h0, rxShift_q[`ARR_CMD_ADR_HI:`ARR_CMD_ADR_LO]};
                    end else if (sclkRise) begin
                        rxShift_q <= {rxShift_q[14:0], mosiS_q[1]};
                        if (bitCnt_q != 5'(`ARR_FRAME_BITS))
                            bitCnt_q <= bitCnt_q + 5'h01;
                        if (rd.capture)
                            txShift_q <= rd.rdData; // R16
                    end else if (sclkFall) begin
                        txShift_q <= {txShift_q[14:0], 1'b0};
                    end
                end
                default: state_q <= ARR_IDLE;
            endcase
        end
    end

    // Bit 15 of every word is zero, so MISO is right before the capture
    assign miso    = txShift_q[15];
    assign misoOeN = (state_q != ARR_SHIFT);

    property p_capture;
        @(posedge clk_sys) disable iff (sys_rst)
        rd.capture |=> txShift_q == $past(rd.rdData);
    endproperty
    a_capture: assert property (p_capture) else $error("read word not latched"); // R16

    property p_no_frame_early;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == ARR_IDLE && !enable) |=> state_q == ARR_IDLE;
    endproperty
    a_no_frame_early: assert property (p_no_frame_early) else $error("frame before ready"); // R12
endmodule : arr_serial

// ---- rtl/arr_readout.sv ----
/*
 Angle readout: main filtered path, low-power secondary path, field
 reading, status bits and the serial register words. Assumes the front
 end delivers a raw 15-bit angle and field value on clk_sys, and that
 stored configuration is stable while sys_rst is high.
*/
`timescale 1ns/1ns
`include "arr_cfg.svh"
module arr_readout #(
    parameter int PorCycles = `ARR_POR_CYC
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // Front end samples, same clock
    input  wire arr_pkg::arr_angle_t feAngle,
    input  wire logic [11:0]   feField,
    // Supply monitor pin, asynchronous
    input  wire logic          lowSupply,
    // Stored configuration
    input  wire arr_pkg::arr_angle_t nvmZeroOffset,
    input  wire arr_pkg::arr_rate_t  nvmAvgRate,
    input  wire logic          nvmOffsetEn,
    input  wire logic          nvmFilterEn,
    input  wire logic          nvmDiagEn,
    // Serial pins
    input  wire logic          sclk,
    input  wire logic          csN,
    input  wire logic          mosi,
    output logic               miso,
    output logic               misoOeN,
    // Angle outputs and status
    output arr_pkg::arr_angle_t encAngle,
    output logic [11:0]        pwmAngle,
    output logic               generalError,
    output logic               serialReady
);
    import arr_pkg::*;

    localparam int AngCyc = `ARR_ANG_CYC;
    localparam int LpCyc  = `ARR_LP_CYC;
    localparam int FdCyc  = `ARR_FIELD_CYC;
    localparam int Taps   = `ARR_RESP_TAPS;
    localparam int AngW   = $clog2(AngCyc);
    localparam int LpW    = $clog2(LpCyc);
    localparam int FdW    = $clog2(FdCyc);
    localparam int PorW   = $clog2(PorCycles + 1);
    localparam int DlyN   = Taps - 2;

    // Shadow configuration
    logic            loadPend_q;
    arr_angle_t      zeroOff_q;
    arr_rate_t       avgRate_q;
    logic            offsetEn_q;
    logic            filterEn_q;
    logic            diagEn_q;
    // Timing
    logic [AngW-1:0] angCnt_q;
    logic [LpW-1:0]  lpCnt_q;
    logic [FdW-1:0]  fdCnt_q;
    logic [PorW-1:0] porCnt_q;
    logic            angTick;
    logic            lpTick;
    logic            fdTick;
    logic            porDone_q;
    // Main path
    arr_angle_t      avg_q;
    arr_angle_t      avg_d;
    arr_angle_t      avgDiff;
    arr_angle_t      avgStep;
    arr_angle_t      dly_q [DlyN];
    arr_angle_t      outAngle;
    // Secondary path and status
    arr_angle_t      lpAngle_q;
    arr_angle_t      diagDiff;
    logic [11:0]     fieldReg_q;
    logic            lsS1_q;
    logic            lsS2_q;
    logic            err_q;
    arr_word_t       word12;
    arr_word_t       word15;

    arr_rd_if rdIf ();

    // Stored config is copied on the first cycle after reset release
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            loadPend_q <= 1'b1; // R19
        end else begin
            loadPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            zeroOff_q  <= `ARR_ANGLE_RST;
            avgRate_q  <= 3'h0;
            offsetEn_q <= 1'b0;
            filterEn_q <= 1'b0;
            diagEn_q   <= 1'b0;
        end else if (loadPend_q) begin
            zeroOff_q  <= nvmZeroOffset; // R19
            avgRate_q  <= nvmAvgRate;
            offsetEn_q <= nvmOffsetEn;   // R13
            filterEn_q <= nvmFilterEn;   // R13
            diagEn_q   <= nvmDiagEn;     // R13
        end
    end

    // Refresh divider: one tick per microsecond
    always_ff @(posedge clk_sys) begin
        if (sys_rst || angTick) begin
            angCnt_q <= '0;
        end else begin
            angCnt_q <= angCnt_q + 1'b1;
        end
    end
    assign angTick = (angCnt_q == AngW'(AngCyc - 1)); // R2

    // Slow dividers for the low-power path and the field reading
    always_ff @(posedge clk_sys) begin
        if (sys_rst || lpTick) begin
            lpCnt_q <= '0;
        end else begin
            lpCnt_q <= lpCnt_q + 1'b1;
        end
    end
    assign lpTick = (lpCnt_q == LpW'(LpCyc - 1)); // R17

    always_ff @(posedge clk_sys) begin
        if (sys_rst || fdTick) begin
            fdCnt_q <= '0;
        end else begin
            fdCnt_q <= fdCnt_q + 1'b1;
        end
    end
    assign fdTick = (fdCnt_q == FdW'(FdCyc - 1)); // R18

    // Power-on wait before serial frames are honoured
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            porCnt_q  <= '0;
            porDone_q <= 1'b0;
        end else if (!porDone_q) begin
            porCnt_q  <= porCnt_q + 1'b1;
            porDone_q <= (porCnt_q == PorW'(PorCycles - 1)); // R12
        end
    end
    assign serialReady = porDone_q;

    // Averaging: modulo difference keeps the filter right across zero
    always_comb begin
        avgDiff = feAngle - avg_q;
        avgStep = arr_angle_t'($signed(avgDiff) >>> avgRate_q);
        if (!filterEn_q || avgRate_q == 3'h0) begin
            avg_d = feAngle; // R13
        end else begin
            avg_d = avg_q + avgStep;
        end
    end

    // Main path: filter stage, delay taps, offset stage, one per tick
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            avg_q <= `ARR_ANGLE_RST;
        end else if (angTick) begin
            avg_q <= avg_d; // R1
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DlyN; gi++) begin : g_dly
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    dly_q[gi] <= `ARR_ANGLE_RST;
                end else if (angTick) begin
                    dly_q[gi] <= (gi == 0) ? avg_q : dly_q[(gi == 0) ? 0 : gi - 1]; // R3
                end
            end
        end
    endgenerate

    // Zero position moved by subtraction, wrapping over the full circle
    assign outAngle = offsetEn_q ? dly_q[DlyN-1] - zeroOff_q : dly_q[DlyN-1]; // R11 R14

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            encAngle <= `ARR_ANGLE_RST;
            pwmAngle <= 12'h000;
        end else if (angTick) begin
            encAngle <= outAngle;        // R10
            pwmAngle <= outAngle[14:3];  // R9 R14
        end
    end

    // Low-power path samples rarely; field reading rarer still
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lpAngle_q <= `ARR_ANGLE_RST;
        end else if (lpTick) begin
            lpAngle_q <= feAngle; // R1 R17
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fieldReg_q <= 12'h000;
        end else if (fdTick) begin
            fieldReg_q <= feField; // R18
        end
    end

    // Diagnostic compare of both paths; the limit absorbs path lag
    assign diagDiff = lpAngle_q - avg_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            err_q <= 1'b0;
        end else if (!diagEn_q) begin
            err_q <= 1'b0; // R13
        end else if (lpTick) begin
            err_q <= (diagDiff > `ARR_DIAG_LIM) && (diagDiff < -`ARR_DIAG_LIM); // R1
        end
    end
    assign generalError = err_q;

    // Supply monitor pin through two flip-flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lsS1_q <= 1'b0;
            lsS2_q <= 1'b0;
        end else begin
            lsS1_q <= lowSupply;
            lsS2_q <= lsS1_q; // R8
        end
    end

    // Read words; parity bit makes the whole word odd
    always_comb begin
        word12 = {1'b0, err_q, lsS2_q, 1'b0, encAngle[14:3]};     // R5 R7
        word12[`ARR_W12_PAR] = ~(^word12);                         // R15
        word15 = {1'b0, encAngle};                                 // R6
    end

    // Width chosen only by the address read
    always_comb begin
        case (rdIf.reqAddr)
            `ARR_REG_ANG12: rdIf.rdData = word12; // R4
            `ARR_REG_ANG15: rdIf.rdData = word15; // R4
            `ARR_REG_FIELD: rdIf.rdData = {4'h0, fieldReg_q};
            default:        rdIf.rdData = `ARR_WORD_RST;
        endcase
    end

    arr_serial u_serial (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .enable  (porDone_q),
        .sclk    (sclk),
        .csN     (csN),
        .mosi    (mosi),
        .miso    (miso),
        .misoOeN (misoOeN),
        .rd      (rdIf.serial)
    );

    // Checks
    property p_tick_period;
        @(posedge clk_sys) disable iff (sys_rst)
        angTick |-> ##25 angTick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("refresh not 1 us"); // R2

    property p_word12;
        @(posedge clk_sys) disable iff (sys_rst)
        (rdIf.reqAddr == `ARR_REG_ANG12) |->
            (rdIf.rdData[15] == 1'b0) && ((^rdIf.rdData) == 1'b1)
            && (rdIf.rdData[11:0] == pwmAngle);
    endproperty
    a_word12: assert property (p_word12) else $error("12-bit word wrong"); // R5

    property p_word15;
        @(posedge clk_sys) disable iff (sys_rst)
        (rdIf.reqAddr == `ARR_REG_ANG15) |-> rdIf.rdData == {1'b0, encAngle};
    endproperty
    a_word15: assert property (p_word15) else $error("15-bit word wrong"); // R6

    property p_pwm_from_enc;
        @(posedge clk_sys) disable iff (sys_rst)
        angTick |=> pwmAngle == $past(outAngle[14:3]);
    endproperty
    a_pwm_from_enc: assert property (p_pwm_from_enc) else $error("pwm angle mismatch"); // R9

    sequence s_supply_low;
        lowSupply ##1 lowSupply;
    endsequence
    property p_low_supply;
        @(posedge clk_sys) disable iff (sys_rst)
        s_supply_low |-> ##1 word12[`ARR_W12_LOWSUP];
    endproperty
    a_low_supply: assert property (p_low_supply) else $error("low supply flag missing"); // R8

    property p_lp_refresh;
        @(posedge clk_sys) disable iff (sys_rst)
        $changed(lpAngle_q) |-> $past(lpTick);
    endproperty
    a_lp_refresh: assert property (p_lp_refresh) else $error("lp angle off tick"); // R17

    property p_field_refresh;
        @(posedge clk_sys) disable iff (sys_rst)
        $changed(fieldReg_q) |-> $past(fdTick);
    endproperty
    a_field_refresh: assert property (p_field_refresh) else $error("field off tick"); // R18

    sequence s_release;
        sys_rst ##1 !sys_rst;
    endsequence
    property p_shadow;
        @(posedge clk_sys)
        s_release |=> zeroOff_q == $past(nvmZeroOffset);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not reloaded"); // R19

    property p_offset;
        @(posedge clk_sys) disable iff (sys_rst)
        (angTick && offsetEn_q) |=> encAngle == $past(dly_q[DlyN-1]) - zeroOff_q;
    endproperty
    a_offset: assert property (p_offset) else $error("offset not applied"); // R11
endmodule : arr_readout

// ---- bench/arr_host.sv ----
/*
 Host side model: a serial master that sends 16-bit mode 0 frames.
 Assumes the device samples sclk, csN and mosi on its own clock.
*/
`timescale 1ns/1ns
module arr_host (
    // Clock for pacing
    input  wire logic clk_sys,
    // Serial pins
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic misoOeN
);
    // Idle: clock stands still low, select high
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end

    // One frame, MSB first; 160 ns half period
    task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp,
                         output logic drv);
        int i;
        drv = 1'b0;
        rsp = 16'h0000;
        @(negedge clk_sys) csN = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (i = 15; i >= 0; i--) begin
            mosi = cmd[i];
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            // Late in the high phase, long after the last shift
            rsp[i] = miso;
            drv = drv | (misoOeN === 1'b0);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        csN = 1'b1;
        // Released line shows no stale value
        mosi = ~mosi;
        repeat (8) @(negedge clk_sys);
    endtask : frame
endmodule : arr_host

// ---- bench/arr_readout_tb.sv ----
/*
 Self-checking bench of the angle readout block against an integer model.
 Assumes arr_host as the serial master and a short power-on count.
*/
`timescale 1ns/1ns
module arr_readout_tb;
    import arr_pkg::*;
    localparam int PorCyc = 200;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    arr_angle_t  feAngle = 15'h0000;
    logic [11:0] feField = 12'h000;
    logic        lowSupply = 1'b0;
    arr_angle_t  nvmZeroOffset = 15'h0000;
    arr_rate_t   nvmAvgRate = 3'h0;
    logic        nvmOffsetEn = 1'b1;
    logic        nvmFilterEn = 1'b0;
    logic        nvmDiagEn = 1'b0;
    logic        ramp = 1'b0;
    logic        sclk, csN, mosi, miso, misoOeN, generalError, serialReady;
    arr_angle_t  encAngle, prev;
    logic [11:0] pwmAngle;
    arr_word_t   rsp;
    logic        drv;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          seed = 64619;
    int          mOff, e, r, t, k, n, last;
    arr_word_t   expQ[$];
    time         relT;

    arr_readout #(.PorCycles(PorCyc)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .feAngle(feAngle),
        .feField(feField), .lowSupply(lowSupply),
        .nvmZeroOffset(nvmZeroOffset), .nvmAvgRate(nvmAvgRate),
        .nvmOffsetEn(nvmOffsetEn), .nvmFilterEn(nvmFilterEn),
        .nvmDiagEn(nvmDiagEn), .sclk(sclk), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOeN(misoOeN), .encAngle(encAngle),
        .pwmAngle(pwmAngle), .generalError(generalError),
        .serialReady(serialReady));
    arr_host host (.clk_sys(clk_sys), .sclk(sclk), .csN(csN), .mosi(mosi),
                   .miso(miso), .misoOeN(misoOeN));

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    // Input ramp, one step each cycle, makes every tick visible
    always @(negedge clk_sys) if (ramp) feAngle <= feAngle + 15'h0001;
    // Watchdog for any hang
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Model of the 12-bit word, odd parity over all 16 bits
    function automatic logic [15:0] w12(int a, logic err, logic lo);
        logic [11:0] g;
        g = a[14:3];
        return {1'b0, err, lo, ~^{err, lo, g}, g};
    endfunction : w12

    // Address frame, then the frame that returns its word
    task automatic read_reg(input logic [5:0] a, input logic wr,
                            output arr_word_t w);
        host.frame({1'b0, wr, a, 8'h00}, w, drv);
        host.frame({2'b00, a, 8'h00}, w, drv);
        check(drv, 1'b1);
        check(misoOeN, 1'b1);
    endtask : read_reg

    // Reset, refused early frame, power-on wait, cleared address
    task automatic do_reset(input int cyc);
        @(negedge clk_sys) sys_rst = 1'b1;
        repeat (cyc) @(negedge clk_sys);
        check(encAngle, 16'h0000);
        check({serialReady, misoOeN}, 16'h0001);
        sys_rst = 1'b0;
        relT = $time;
        mOff = nvmOffsetEn ? int'(nvmZeroOffset) : 0;
        host.frame(16'h2000, rsp, drv);
        check(drv, 1'b0);
        for (k = 0; k < 400 && serialReady !== 1'b1; k++) @(negedge clk_sys);
        if (serialReady !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        check(16'(($time - relT) / 40), 16'(PorCyc));
        host.frame(16'h3200, rsp, drv);
        check(rsp, 16'h0000);
        $display("reset test done");
    endtask : do_reset

    initial begin
        r = $random(seed);
        nvmZeroOffset = r[14:0];
        do_reset(16);
        // Random angles, fields and supply states across all words
        for (t = 0; t < 6; t++) begin
            r = $random(seed);
            @(negedge clk_sys);
            feAngle = r[14:0];
            lowSupply = r[15];
            feField = r[27:16];
            repeat (3300) @(negedge clk_sys);
            e = (int'(feAngle) - mOff) & 32'h7FFF;
            check(encAngle, e[15:0]);
            check(pwmAngle, 16'(e >> 3));
            check(generalError, 1'b0);
            // Expected words queued in read order
            expQ.push_back(w12(e, 1'b0, lowSupply));
            expQ.push_back(e[15:0]);
            expQ.push_back({4'h0, feField});
            expQ.push_back(16'h0000);
            read_reg(6'h20, r[31], rsp);
            check(rsp, expQ.pop_front());
            read_reg(6'h32, r[30], rsp);
            check(rsp, expQ.pop_front());
            read_reg(6'h2A, 1'b0, rsp);
            check(rsp, expQ.pop_front());
            read_reg(6'h15, 1'b0, rsp);
            check(rsp, expQ.pop_front());
        end
        $display("register test done");
        // Ramp: latency of first change, then one update per tick
        lowSupply = 1'b0;
        prev = encAngle;
        n = 0;
        last = 0;
        ramp = 1'b1;
        for (k = 1; k <= 400 && n < 5; k++) begin
            @(negedge clk_sys);
            if (encAngle !== prev) begin
                if (n == 0) check(k >= 150 && k <= 205, 1'b1);
                else check(16'(k - last), 16'h0019);
                n++;
                last = k;
                prev = encAngle;
            end
        end
        check(16'(n), 16'h0005);
        // Word taken whole although the angle moves under the frame
        read_reg(6'h20, 1'b0, rsp);
        check({rsp[15], ^rsp}, 16'h0001);
        @(negedge clk_sys) ramp = 1'b0;
        $display("timing test done");
        // New stored offset and diagnostics take hold only at reset
        r = $random(seed);
        nvmZeroOffset = r[14:0];
        nvmDiagEn = 1'b1;
        // Angle far from the reset value of the secondary path
        feAngle = {2'b01, r[27:15]};
        do_reset(2);
        // First secondary sample compares a stale zero with the main path
        for (k = 0; k < 2000 && ($time - relT) < 40000; k++) @(negedge clk_sys);
        check(generalError, 1'b1);
        repeat (3300) @(negedge clk_sys);
        e = (int'(feAngle) - mOff) & 32'h7FFF;
        check(encAngle, e[15:0]);
        check(generalError, 1'b0);
        read_reg(6'h20, 1'b0, rsp);
        check(rsp, w12(e, 1'b0, 1'b0));
        $display("reload test done");
        wrap_up();
    end
endmodule : arr_readout_tb
